/* File: design/pin_mux_pkg.sv */
package pin_mux_pkg;
  // ==========================================
  // widths and reset values
  localparam int PORT_W = 8;
  localparam int HI_ADDR_W = 4;
  localparam int ANALOG_W = 16;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [3:0] HI_ADDR_CTL_RST = 4'h0;
  // ==========================================
  // external pin control bit positions
  localparam int EPC_WR_EN = 0;
  localparam int EPC_HOLD_EN = 1;
  localparam int EPC_RDY_EN = 2;
  localparam int EPC_CLK_EN = 3;
  localparam int EPC_W = 4;
  localparam logic [3:0] EPC_RST = 4'h0;
  // ==========================================
  // port 5 pin positions
  localparam int P5_ALE = 0;
  localparam int P5_RD = 1;
  localparam int P5_WR_LOW = 2;
  localparam int P5_WR_HIGH = 3;
  localparam int P5_HOLD_REQ = 4;
  localparam int P5_HOLD_ACK = 5;
  localparam int P5_RDY = 6;
  localparam int P5_CLK = 7;
  // ==========================================
  // bus mode states
  typedef enum logic [2:0] {
    MODE_SINGLE = 3'b001,
    MODE_MUX = 3'b010,
    MODE_NONMUX = 3'b100
  } bus_mode_t;
endpackage

/* File: design/pin_route.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_route #(
  parameter int W = 8
) (
  input wire logic [W-1:0] sel,
  input wire logic [W-1:0] fn_out,
  input wire logic [W-1:0] fn_oe_n,
  input wire logic [W-1:0] port_out,
  input wire logic [W-1:0] port_oe_n,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_n
);
  // ==========================================
  // per-pin select: function or port latch, never both
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      assign pin_out[i] = sel[i] ? fn_out[i] : port_out[i];
      assign pin_oe_n[i] = sel[i] ? fn_oe_n[i] : port_oe_n[i];
    end
  endgenerate
endmodule
`default_nettype wire

/* File: design/port_pin_function_selector.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - high address control one makes pin port, or pulse generator output if enabled
// - high address control zero drives address 20-23 in bus mode
// - non-multiplexed mode: ports 3,4 drive address
// - bus mode: ALE and read strobe out
// - low write strobe needs write enable
// - high write strobe needs 16-bit bus too
// - hold enable routes hold request/acknowledge
// - ready enable routes ready input
// - clock enable drives machine clock out
// - pulse generator outputs on ports 2, 11
// - reload timers get event in/out pins
// - four UARTs: rx, tx, bidirectional clock
// - port 6: interrupts, serial, pulse width, I2C
// - ports 7, 8 carry analog inputs
// - shared pin: trigger and free-run clock
// - port 10: capture in, compare out
// - function pin is never also port
// - analog passes only when enabled
module port_pin_function_selector
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire pin_mux_pkg::bus_mode_t bus_mode,
  input wire logic bus_16bit,
  input wire logic [pin_mux_pkg::HI_ADDR_W-1:0] high_address_output_control,
  input wire logic [pin_mux_pkg::EPC_W-1:0] external_pin_control,
  input wire logic [pin_mux_pkg::ANALOG_W-1:0] analog_input_enable_reg,
  input wire logic [3:0] pulse_gen_en,
  input wire logic [1:0] pulse_gen_hi_en,
  input wire logic [2:0] reload_timer_out_en,
  input wire logic [3:0] serial_tx_en,
  input wire logic [3:0] serial_clk_master,
  input wire logic [3:0] compare_out_en,
  input wire logic simple_serial_tx_en,
  input wire logic simple_serial_clk_master,
  // bus controller side
  input wire logic [23:0] bus_addr,
  input wire logic bus_ale,
  input wire logic bus_rd_n,
  input wire logic bus_wr_low_n,
  input wire logic bus_wr_high_n,
  input wire logic bus_hold_ack,
  input wire logic machine_clk_out,
  output logic bus_hold_request,
  output logic bus_ready,
  // peripheral side
  input wire logic [5:0] pulse_gen_out,
  input wire logic [2:0] reload_timer_out,
  input wire logic [3:0] serial_tx,
  input wire logic [3:0] serial_clk_o,
  input wire logic [3:0] compare_event_out,
  input wire logic simple_serial_tx,
  input wire logic simple_serial_clk_o,
  output logic [2:0] reload_timer_event_in,
  output logic [3:0] serial_rx,
  output logic [3:0] serial_clk_i,
  output logic [7:0] ext_irq_in,
  output logic simple_serial_rx,
  output logic simple_serial_clk_i,
  output logic pulse_width_meas_in,
  output logic i2c0_scl_in,
  output logic i2c0_sda_in,
  output logic converter_ext_trigger,
  output logic freerun_ext_clock,
  output logic [3:0] capture_trigger,
  output logic [pin_mux_pkg::ANALOG_W-1:0] analog_in,
  // port latches (out and active-low enable) and pins
  input wire logic [7:0] p2_latch,
  input wire logic [7:0] p2_oe_n_latch,
  input wire logic [7:0] p3_latch,
  input wire logic [7:0] p3_oe_n_latch,
  input wire logic [7:0] p4_latch,
  input wire logic [7:0] p4_oe_n_latch,
  input wire logic [7:0] p5_latch,
  input wire logic [7:0] p5_oe_n_latch,
  input wire logic [7:0] p9_latch,
  input wire logic [7:0] p9_oe_n_latch,
  input wire logic [7:0] pa_latch,
  input wire logic [7:0] pa_oe_n_latch,
  input wire logic [7:0] pb_latch,
  input wire logic [7:0] pb_oe_n_latch,
  input wire logic [7:0] p2_in,
  input wire logic [7:0] p3_in,
  input wire logic [7:0] p4_in,
  input wire logic [7:0] p5_in,
  input wire logic [7:0] p6_in,
  input wire logic [15:0] p78_in,
  input wire logic [7:0] p9_in,
  input wire logic [7:0] pa_in,
  output logic [7:0] p2_out,
  output logic [7:0] p2_oe_n,
  output logic [7:0] p3_out,
  output logic [7:0] p3_oe_n,
  output logic [7:0] p4_out,
  output logic [7:0] p4_oe_n,
  output logic [7:0] p5_out,
  output logic [7:0] p5_oe_n,
  output logic [7:0] p9_out,
  output logic [7:0] p9_oe_n,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe_n,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe_n,
  output logic [7:0] p2_fn_sel,
  output logic [7:0] p3_fn_sel,
  output logic [7:0] p4_fn_sel,
  output logic [7:0] p5_fn_sel
);
  import pin_mux_pkg::*;

  // ==========================================
  // registered state: selects and function data
  typedef struct packed {
    logic [7:0] s2, s3, s4, s5, s9, sa, sb;
    logic [7:0] f2, f3, f4, f5, f9, fa, fb;
    logic [7:0] e2, e3, e4, e5, e9, ea, eb;
  } st_t;
  st_t st_r, st_nxt;

  logic ext_bus, nonmux;
  assign ext_bus = (bus_mode != MODE_SINGLE);
  assign nonmux = (bus_mode == MODE_NONMUX);

  // ==========================================
  // selection; registered so pins move on the next clock
  always_comb begin
    st_nxt = '0;
    st_nxt.e2 = 8'hff;
    st_nxt.e3 = 8'hff;
    st_nxt.e4 = 8'hff;
    st_nxt.e5 = 8'hff;
    st_nxt.e9 = 8'hff;
    st_nxt.ea = 8'hff;
    st_nxt.eb = 8'hff;
    // port 2: address 16-23 or pulse generator 0-3
    for (int i = 0; i < 4; i++) begin
      st_nxt.s2[i] = ext_bus;
      st_nxt.f2[i] = bus_addr[16+i];
      st_nxt.e2[i] = ~ext_bus;
    end
    for (int i = 0; i < HI_ADDR_W; i++) begin
      if (ext_bus && !high_address_output_control[i]) begin
        st_nxt.s2[4+i] = 1'b1;
        st_nxt.f2[4+i] = bus_addr[20+i];
        st_nxt.e2[4+i] = 1'b0;
      end else if (pulse_gen_en[i]) begin
        st_nxt.s2[4+i] = 1'b1;
        st_nxt.f2[4+i] = pulse_gen_out[i];
        st_nxt.e2[4+i] = 1'b0;
      end
    end
    // ports 3 and 4: low address or timer and uart pins
    if (nonmux) begin
      st_nxt.s3 = 8'hff;
      st_nxt.f3 = bus_addr[7:0];
      st_nxt.e3 = 8'h00;
      st_nxt.s4 = 8'hff;
      st_nxt.f4 = bus_addr[15:8];
      st_nxt.e4 = 8'h00;
    end else begin
      for (int t = 1; t < 3; t++) begin
        st_nxt.s3[2*t-1] = reload_timer_out_en[t];
        st_nxt.f3[2*t-1] = reload_timer_out[t];
        st_nxt.e3[2*t-1] = ~reload_timer_out_en[t];
      end
      st_nxt.s4[1] = reload_timer_out_en[0];
      st_nxt.f4[1] = reload_timer_out[0];
      st_nxt.e4[1] = ~reload_timer_out_en[0];
      for (int u = 0; u < 2; u++) begin
        st_nxt.s4[3+3*u] = serial_tx_en[u];
        st_nxt.f4[3+3*u] = serial_tx[u];
        st_nxt.e4[3+3*u] = ~serial_tx_en[u];
        st_nxt.s4[4+3*u] = serial_clk_master[u];
        st_nxt.f4[4+3*u] = serial_clk_o[u];
        st_nxt.e4[4+3*u] = ~serial_clk_master[u];
      end
    end
    // port 5: bus control strobes
    if (ext_bus) begin
      st_nxt.s5[P5_ALE] = 1'b1;
      st_nxt.f5[P5_ALE] = bus_ale;
      st_nxt.e5[P5_ALE] = 1'b0;
      st_nxt.s5[P5_RD] = 1'b1;
      st_nxt.f5[P5_RD] = bus_rd_n;
      st_nxt.e5[P5_RD] = 1'b0;
      if (external_pin_control[EPC_WR_EN]) begin
        st_nxt.s5[P5_WR_LOW] = 1'b1;
        st_nxt.f5[P5_WR_LOW] = bus_wr_low_n;
        st_nxt.e5[P5_WR_LOW] = 1'b0;
        st_nxt.s5[P5_WR_HIGH] = bus_16bit;
        st_nxt.f5[P5_WR_HIGH] = bus_wr_high_n;
        st_nxt.e5[P5_WR_HIGH] = ~bus_16bit;
      end
      if (external_pin_control[EPC_HOLD_EN]) begin
        st_nxt.s5[P5_HOLD_REQ] = 1'b1;
        st_nxt.s5[P5_HOLD_ACK] = 1'b1;
        st_nxt.f5[P5_HOLD_ACK] = bus_hold_ack;
        st_nxt.e5[P5_HOLD_ACK] = 1'b0;
      end
      st_nxt.s5[P5_RDY] = external_pin_control[EPC_RDY_EN];
      if (external_pin_control[EPC_CLK_EN]) begin
        st_nxt.s5[P5_CLK] = 1'b1;
        st_nxt.f5[P5_CLK] = machine_clk_out;
        st_nxt.e5[P5_CLK] = 1'b0;
      end
    end
    // port 9: uart 2 and 3
    for (int u = 0; u < 2; u++) begin
      st_nxt.s9[1+3*u] = serial_tx_en[2+u];
      st_nxt.f9[1+3*u] = serial_tx[2+u];
      st_nxt.e9[1+3*u] = ~serial_tx_en[2+u];
      st_nxt.s9[2+3*u] = serial_clk_master[2+u];
      st_nxt.f9[2+3*u] = serial_clk_o[2+u];
      st_nxt.e9[2+3*u] = ~serial_clk_master[2+u];
    end
    // port 10: compare outputs on upper half
    for (int c = 0; c < 4; c++) begin
      st_nxt.sa[4+c] = compare_out_en[c];
      st_nxt.fa[4+c] = compare_event_out[c];
      st_nxt.ea[4+c] = ~compare_out_en[c];
    end
    // port 11: pulse generator 4 and 5
    for (int k = 0; k < 2; k++) begin
      st_nxt.sb[5+k] = pulse_gen_hi_en[k];
      st_nxt.fb[5+k] = pulse_gen_out[4+k];
      st_nxt.eb[5+k] = ~pulse_gen_hi_en[k];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.e2 <= 8'hff;
      st_r.e3 <= 8'hff;
      st_r.e4 <= 8'hff;
      st_r.e5 <= 8'hff;
      st_r.e9 <= 8'hff;
      st_r.ea <= 8'hff;
      st_r.eb <= 8'hff;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // output muxing through one shared router
  logic [55:0] sel_all, fn_all, fe_all, po_all, pe_all, out_all, oe_all;
  assign sel_all = {st_r.s2, st_r.s3, st_r.s4, st_r.s5, st_r.s9, st_r.sa, st_r.sb};
  assign fn_all = {st_r.f2, st_r.f3, st_r.f4, st_r.f5, st_r.f9, st_r.fa, st_r.fb};
  assign fe_all = {st_r.e2, st_r.e3, st_r.e4, st_r.e5, st_r.e9, st_r.ea, st_r.eb};
  assign po_all = {p2_latch, p3_latch, p4_latch, p5_latch, p9_latch, pa_latch, pb_latch};
  assign pe_all = {p2_oe_n_latch, p3_oe_n_latch, p4_oe_n_latch, p5_oe_n_latch,
                   p9_oe_n_latch, pa_oe_n_latch, pb_oe_n_latch};

  pin_route #(.W(56)) u_route (
    .sel(sel_all),
    .fn_out(fn_all),
    .fn_oe_n(fe_all),
    .port_out(po_all),
    .port_oe_n(pe_all),
    .pin_out(out_all),
    .pin_oe_n(oe_all)
  );

  assign {p2_out, p3_out, p4_out, p5_out, p9_out, pa_out, pb_out} = out_all;
  assign {p2_oe_n, p3_oe_n, p4_oe_n, p5_oe_n, p9_oe_n, pa_oe_n, pb_oe_n} = oe_all;
  assign p2_fn_sel = st_r.s2;
  assign p3_fn_sel = st_r.s3;
  assign p4_fn_sel = st_r.s4;
  assign p5_fn_sel = st_r.s5;

  // ==========================================
  // inputs to peripherals; timer and uart inputs gated while the pin is a bus pin, hold request and ready taken only then
  assign bus_hold_request = st_r.s5[P5_HOLD_REQ] & p5_in[P5_HOLD_REQ];
  assign bus_ready = st_r.s5[P5_RDY] ? p5_in[P5_RDY] : 1'b1;
  assign reload_timer_event_in = {p3_in[2], p3_in[0], p4_in[0]} & {3{~nonmux}};
  assign serial_rx = {p9_in[3], p9_in[0], p4_in[5], p4_in[2]}
                     & {2'b11, {2{~nonmux}}};
  assign serial_clk_i = {p9_in[5], p9_in[2], p4_in[7], p4_in[4]} & {2'b11, {2{~nonmux}}};
  assign ext_irq_in = p6_in;
  assign simple_serial_rx = p6_in[2];
  assign simple_serial_clk_i = p6_in[4];
  assign pulse_width_meas_in = p6_in[5];
  // the i2c pads are open drain; port must be tristated by software
  assign i2c0_scl_in = p6_in[6];
  assign i2c0_sda_in = p6_in[7];
  assign converter_ext_trigger = p9_in[6];
  assign freerun_ext_clock = p9_in[6];
  assign capture_trigger = pa_in[3:0];
  assign analog_in = p78_in & analog_input_enable_reg;

  // ==========================================
  // checks
  property p_hi_addr;
    @(posedge clk) disable iff (!resetn)
    (ext_bus && !high_address_output_control[0])
      |=> (p2_out[4] == $past(bus_addr[20])) && !p2_oe_n[4];
  endproperty
  a_hi_addr: assert property (p_hi_addr) else $error("address 20 not driven");

  property p_hi_port;
    @(posedge clk) disable iff (!resetn)
    (ext_bus && high_address_output_control[1] && !pulse_gen_en[1]) |=> !p2_fn_sel[5];
  endproperty
  a_hi_port: assert property (p_hi_port) else $error("pin 25 not port");

  property p_nonmux;
    @(posedge clk) disable iff (!resetn)
    nonmux |=> (p3_out == $past(bus_addr[7:0])) && (p4_out == $past(bus_addr[15:8]));
  endproperty
  a_nonmux: assert property (p_nonmux) else $error("low address not driven");

  property p_ale;
    @(posedge clk) disable iff (!resetn)
    ext_bus |=> p5_fn_sel[P5_ALE] && p5_fn_sel[P5_RD];
  endproperty
  a_ale: assert property (p_ale) else $error("strobes not routed");

  property p_wr_low;
    @(posedge clk) disable iff (!resetn)
    !external_pin_control[EPC_WR_EN] |=> !p5_fn_sel[P5_WR_LOW];
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("write strobe without enable");

  property p_wr_high;
    @(posedge clk) disable iff (!resetn)
    !bus_16bit |=> !p5_fn_sel[P5_WR_HIGH];
  endproperty
  a_wr_high: assert property (p_wr_high) else $error("high strobe in 8-bit bus");

  property p_clk;
    @(posedge clk) disable iff (!resetn)
    (ext_bus && external_pin_control[EPC_CLK_EN])
      |=> p5_out[P5_CLK] == $past(machine_clk_out);
  endproperty
  a_clk: assert property (p_clk) else $error("clock out wrong");

  property p_analog;
    @(posedge clk) disable iff (!resetn)
    (analog_in & ~analog_input_enable_reg) == '0;
  endproperty
  a_analog: assert property (p_analog) else $error("analog leak");

  property p_excl;
    @(posedge clk) disable iff (!resetn)
    p5_fn_sel[P5_HOLD_ACK] |-> p5_out[P5_HOLD_ACK] == $past(bus_hold_ack);
  endproperty
  a_excl: assert property (p_excl) else $error("port drove function pin");
endmodule
`default_nettype wire

/* File: testbench/board_devices.sv */
`timescale 1ns/10ps
`default_nettype none
module board_devices (
  input wire logic [79:0] board_drive,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p2_oe_n,
  input wire logic [7:0] p3_out,
  input wire logic [7:0] p3_oe_n,
  input wire logic [7:0] p4_out,
  input wire logic [7:0] p4_oe_n,
  input wire logic [7:0] p5_out,
  input wire logic [7:0] p5_oe_n,
  input wire logic [7:0] p9_out,
  input wire logic [7:0] p9_oe_n,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe_n,
  output logic [7:0] p2_in,
  output logic [7:0] p3_in,
  output logic [7:0] p4_in,
  output logic [7:0] p5_in,
  output logic [7:0] p6_in,
  output logic [15:0] p78_in,
  output logic [7:0] p9_in,
  output logic [7:0] pa_in
);
  // ==========================================
  // wire level: chip drive wins, else the board's source
  assign p2_in = (~p2_oe_n & p2_out) | (p2_oe_n & board_drive[7:0]);
  assign p3_in = (~p3_oe_n & p3_out) | (p3_oe_n & board_drive[15:8]);
  assign p4_in = (~p4_oe_n & p4_out) | (p4_oe_n & board_drive[23:16]);
  // hold request and ready come from the board bus master and memories
  assign p5_in = (~p5_oe_n & p5_out) | (p5_oe_n & board_drive[31:24]);
  assign p9_in = (~p9_oe_n & p9_out) | (p9_oe_n & board_drive[39:32]);
  assign pa_in = (~pa_oe_n & pa_out) | (pa_oe_n & board_drive[47:40]);
  // ==========================================
  // port output kept off on i2c lines, so only the board sets them
  assign p6_in = board_drive[55:48];
  assign p78_in = board_drive[71:56];
endmodule
`default_nettype wire

/* File: testbench/tb_port_pin_function_selector.sv */
`timescale 1ns/10ps
`default_nettype none
`define CMP(nm, e, g, m) begin n_checks++; if (((e) & (m)) !== ((g) & (m))) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, (e) & (m), (g) & (m)); end end
module tb_port_pin_function_selector;
  import pin_mux_pkg::*;
  typedef struct {int id; logic [23:0] e; logic [23:0] m;} note_t;
  note_t q[$];
  event chk;
  int mismatches = 0;
  int n_checks = 0;
  logic clk, resetn, bus_16bit, bus_ale, bus_rd_n, bus_wr_low_n, bus_wr_high_n, bus_hold_ack;
  logic machine_clk_out, simple_serial_tx_en, simple_serial_clk_master, simple_serial_tx;
  logic simple_serial_clk_o, bus_hold_request, bus_ready, simple_serial_rx, simple_serial_clk_i;
  logic pulse_width_meas_in, i2c0_scl_in, i2c0_sda_in, converter_ext_trigger, freerun_ext_clock;
  bus_mode_t bus_mode;
  logic [3:0] high_address_output_control, external_pin_control, pulse_gen_en, serial_tx_en;
  logic [3:0] serial_clk_master, compare_out_en, serial_tx, serial_clk_o, compare_event_out;
  logic [3:0] serial_rx, serial_clk_i, capture_trigger;
  logic [1:0] pulse_gen_hi_en;
  logic [2:0] reload_timer_out_en, reload_timer_out, reload_timer_event_in;
  logic [5:0] pulse_gen_out;
  logic [23:0] bus_addr;
  logic [15:0] analog_input_enable_reg, analog_in, p78_in, fe, fo, m34;
  logic [7:0] ext_irq_in, p2_latch, p2_oe_n_latch, p3_latch, p3_oe_n_latch, p4_latch;
  logic [7:0] p4_oe_n_latch, p5_latch, p5_oe_n_latch, p9_latch, p9_oe_n_latch, pa_latch;
  logic [7:0] pa_oe_n_latch, pb_latch, pb_oe_n_latch, p2_in, p3_in, p4_in, p5_in, p6_in, p9_in;
  logic [7:0] pa_in, p2_out, p2_oe_n, p3_out, p3_oe_n, p4_out, p4_oe_n, p5_out, p5_oe_n, p9_out;
  logic [7:0] p9_oe_n, pa_out, pa_oe_n, pb_out, pb_oe_n, p2_fn_sel, p3_fn_sel, p4_fn_sel;
  logic [7:0] p5_fn_sel, inp;
  logic [79:0] board_drive;
  logic bus, nm, w, h, r, c;
  logic [3:0] pe, po;

  port_pin_function_selector u_port_pin_function_selector (.*);
  board_devices u_board_devices (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================
  // scoreboard
  function automatic logic [15:0] mx(input logic [15:0] sel, val, lat);
    return (sel & val) | (~sel & lat);
  endfunction

  function automatic logic [23:0] seen(input int id);
    case (id)
      0: return {p4_out, p3_out};
      1: return {p4_oe_n, p3_oe_n};
      2: return {p2_oe_n, p2_out};
      3: return p5_out;
      4: return p5_oe_n;
      5: return p5_fn_sel;
      6: return {bus_ready, bus_hold_request};
      7: return analog_in;
      8: return {freerun_ext_clock, converter_ext_trigger, ext_irq_in};
      9: return {pb_out[6:5], pa_out[7:4], pa_oe_n[7:4], capture_trigger};
      10: return {pulse_width_meas_in, i2c0_sda_in, i2c0_scl_in, simple_serial_clk_i,
        simple_serial_rx, serial_clk_i, serial_rx, reload_timer_event_in};
      11: return {p9_oe_n, p9_out};
      12: return {p2_fn_sel, p4_fn_sel, p3_fn_sel};
      default: return 24'h00_0000;
    endcase
  endfunction

  task automatic note(input int id, input logic [23:0] e, m);
    q.push_back('{id, e, m});
  endtask

  initial begin
    note_t n;
    forever begin
      @(chk);
      while (q.size() > 0) begin
        n = q.pop_front();
        `CMP($sformatf("item %0d", n.id), n.e, seen(n.id), n.m)
      end
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================
  // stimulus
  task automatic rnd(input int k);
    bus_mode = bus_mode_t'(3'b001 << (k % 3));
    bus_16bit = k[4];
    external_pin_control = k[3:0];
    bus_addr = 24'($urandom);
    high_address_output_control = 4'($urandom);
    analog_input_enable_reg = 16'($urandom);
    board_drive = 80'({$urandom, $urandom, $urandom});
    {pulse_gen_en, pulse_gen_hi_en, reload_timer_out_en, serial_tx_en, serial_clk_master,
     compare_out_en, reload_timer_out, serial_tx, serial_clk_o} = $urandom;
    {pulse_gen_out, compare_event_out, bus_ale, bus_rd_n, bus_wr_low_n, bus_wr_high_n,
     bus_hold_ack, machine_clk_out, simple_serial_tx_en, simple_serial_clk_master,
     simple_serial_tx, simple_serial_clk_o} = 20'($urandom);
    {p2_latch, p2_oe_n_latch, p3_latch, p3_oe_n_latch} = $urandom;
    {p4_latch, p4_oe_n_latch, p5_latch, p5_oe_n_latch} = $urandom;
    {p9_latch, p9_oe_n_latch, pa_latch, pa_oe_n_latch} = $urandom;
    {pb_latch, pb_oe_n_latch} = 16'($urandom);
  endtask

  task automatic run_one(input int k);
    @(negedge clk);
    rnd(k);
    // outputs are registered: give the sampling edge time to land
    repeat (2) @(negedge clk);
    bus = bus_mode != MODE_SINGLE;
    nm = bus_mode == MODE_NONMUX;
    {c, r, h, w} = external_pin_control & {4{bus}};
    fe = nm ? 16'hffff : {serial_clk_master[1], serial_tx_en[1], 1'b0, serial_clk_master[0],
      serial_tx_en[0], 1'b0, reload_timer_out_en[0], 5'h00, reload_timer_out_en[2], 1'b0,
      reload_timer_out_en[1], 1'b0};
    fo = nm ? bus_addr[15:0] : {serial_clk_o[1], serial_tx[1], 1'b0, serial_clk_o[0],
      serial_tx[0], 1'b0, reload_timer_out[0], 5'h00, reload_timer_out[2], 1'b0,
      reload_timer_out[1], 1'b0};
    // every pin of ports 3 and 4 has exactly one owner in every mode
    m34 = 16'hffff;
    note(0, mx(fe, fo, {p4_latch, p3_latch}), m34);
    note(1, mx(fe, 16'h0000, {p4_oe_n_latch, p3_oe_n_latch}), m34);
    pe = {4{bus}} & ~high_address_output_control;
    po = (pe & bus_addr[23:20]) | (~pe & pulse_gen_out[3:0]);
    pe = pe | pulse_gen_en;
    note(12, {pe, {4{bus}}, fe}, 24'hff_ffff);
    note(2, mx({pe, {4{bus}}, pe, {4{bus}}}, {8'h00, po, bus_addr[19:16]},
      {p2_oe_n_latch, p2_latch}), 24'h00_ffff);
    fe = {8'h00, c, r, h, h, w & bus_16bit, w, bus, bus};
    fo = {8'h00, machine_clk_out, 1'b0, bus_hold_ack, 1'b0, bus_wr_high_n, bus_wr_low_n,
      bus_rd_n, bus_ale};
    inp = {1'b0, r, 1'b0, h, 4'h0};
    note(3, mx(fe, fo, p5_latch), 24'h00_00ff);
    note(4, mx(fe, inp, p5_oe_n_latch), 24'h0000_ff);
    note(5, fe, 24'h0000_ff);
    note(6, {r ? board_drive[30] : 1'b1, h & board_drive[28]}, 24'h00_0003);
    note(7, board_drive[71:56] & analog_input_enable_reg, 24'h00_ffff);
    note(8, {{2{p9_oe_n_latch[6] ? board_drive[38] : p9_latch[6]}}, board_drive[55:48]},
      24'h00_03ff);
    fe = {2'b00, pulse_gen_hi_en, compare_out_en, compare_out_en, 4'h0};
    fo = {2'b00, pulse_gen_out[5:4], compare_event_out, 8'h00};
    note(9, mx(fe, fo, {2'b00, pb_latch[6:5], pa_latch[7:4], pa_oe_n_latch[7:4], pa_in[3:0]}),
      24'h00_3fff);
    note(10, {board_drive[53], board_drive[55:54], board_drive[52], board_drive[50],
      p9_in[5], p9_in[2], p4_in[7] & ~nm, p4_in[4] & ~nm, p9_in[3], p9_in[0],
      p4_in[5] & ~nm, p4_in[2] & ~nm, {p3_in[2], p3_in[0], p4_in[0]} & {3{~nm}}},
      24'h00_ffff);
    fe = {8'h00, 2'b00, serial_clk_master[3], serial_tx_en[3], 1'b0,
      serial_clk_master[2], serial_tx_en[2], 1'b0};
    fo = {8'h00, 2'b00, serial_clk_o[3], serial_tx[3], 1'b0,
      serial_clk_o[2], serial_tx[2], 1'b0};
    note(11, mx({fe[7:0], fe[7:0]}, fo, {p9_oe_n_latch, p9_latch}), 24'h00_ffff);
    ->chk;
    $display("test %0d done", k);
  endtask

  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(11));
    resetn = 1'b0;
    rnd(0);
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    for (int k = 0; k < 96; k++) begin
      run_one(k);
    end
    // reset in mid-run from bus mode: functions drop back to ports
    run_one(2 + 15);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    note(5, 24'h0, 24'h0000_ff);
    note(0, {p4_latch, p3_latch}, 24'h00_ffff);
    note(12, 24'h00_0000, 24'hff_ffff);
    note(2, {p2_oe_n_latch, p2_latch}, 24'h00_ffff);
    ->chk;
    resetn = 1'b1;
    $display("test reset done");
    run_one(5);
    repeat (2) @(negedge clk);
    tally_and_finish();
  end
endmodule
`undef CMP
`default_nettype wire
